// ===== design/burst_port_pkg.sv
package burst_port_pkg;

    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned REG_W  = 16;

    // Register byte offsets.
    localparam logic [7:0] OFS_CONTROL_ONE    = 8'h00;
    localparam logic [7:0] OFS_CONTROL_TWO    = 8'h04;
    localparam logic [7:0] OFS_IRQ_DMA_ENABLE = 8'h0C;
    localparam logic [7:0] OFS_STATUS_FLAGS   = 8'h10;
    localparam logic [7:0] OFS_EVENT_GENERATE = 8'h14;
    localparam logic [7:0] OFS_CHANNEL_MODE   = 8'h18;
    localparam logic [7:0] OFS_CHANNEL_EN_POL = 8'h20;
    localparam logic [7:0] OFS_COUNTER_VALUE  = 8'h24;
    localparam logic [7:0] OFS_CLOCK_DIVIDER  = 8'h28;
    localparam logic [7:0] OFS_RELOAD_VALUE   = 8'h2C;
    localparam logic [7:0] OFS_REPETITION     = 8'h30;
    localparam logic [7:0] OFS_COMPARE_VALUE  = 8'h34;
    localparam logic [7:0] OFS_BREAK_DEADTIME = 8'h44;
    localparam logic [7:0] OFS_BURST_CONTROL  = 8'h48;
    localparam logic [7:0] OFS_BURST_WINDOW   = 8'h4C;

    // Number of word slots in the register space.
    localparam int unsigned NUM_SLOTS = 20;

    // Reset value shared by every register.
    localparam logic [15:0] REG_RESET = 16'h0000;

    // Writable masks; MASK_CHAN_MODE_OUT is the output-compare read mask.
    localparam logic [15:0] MASK_CONTROL_ONE    = 16'h038F;
    localparam logic [15:0] MASK_CONTROL_TWO    = 16'h030D;
    localparam logic [15:0] MASK_IRQ_DMA_ENABLE = 16'h0383;
    localparam logic [15:0] MASK_STATUS_FLAGS   = 16'h0283;
    localparam logic [15:0] MASK_CHANNEL_MODE   = 16'h00FF;
    localparam logic [15:0] MASK_CHAN_MODE_OUT  = 16'h007F;
    localparam logic [15:0] MASK_CHANNEL_EN_POL = 16'h000F;
    localparam logic [15:0] MASK_REPETITION     = 16'h00FF;
    localparam logic [15:0] MASK_BURST_CONTROL  = 16'h1F1F;
    localparam logic [15:0] MASK_FULL           = 16'hFFFF;

    // Field positions.
    localparam int unsigned UPD_DMA_EN_BIT = 8;
    localparam int unsigned UPD_FLAG_BIT   = 0;
    localparam int unsigned UPD_GEN_BIT    = 0;
    localparam int unsigned BASE_OFS_LSB   = 0;
    localparam int unsigned LEN_CODE_LSB   = 8;
    localparam int unsigned BURST_FLD_W    = 5;
    localparam int unsigned CHAN_DIR_LSB   = 0;

    // Largest burst length code: eighteen transfers.
    localparam logic [4:0] BURST_LEN_MAX = 5'h11;

    // Channel direction codes.
    localparam logic [1:0] CHAN_DIR_OUT = 2'h0;

    // Wait states before pready.
    localparam int unsigned APB_WAIT = 0;

endpackage : burst_port_pkg

// ===== design/burst_sequencer.sv
`timescale 1ns/1ps
module burst_sequencer
    import burst_port_pkg::*;
#(
    parameter int unsigned FLD_W = BURST_FLD_W
)
(
    // Clock and reset.
    input  wire logic             clk_i,
    input  wire logic             sys_rst_i,
    // Control.
    input  wire logic             update_evt_i,
    input  wire logic             dma_en_i,
    input  wire logic [FLD_W-1:0] burst_length_i,
    input  wire logic             window_xfer_i,
    // State.
    output logic      [FLD_W-1:0] burst_index_o,
    output logic                  dma_req_o
);

    if (FLD_W < 5)
    begin : g_bad_width
        $error("burst_sequencer needs at least 5 index bits");
    end

    typedef enum logic [0:0] {SEQ_IDLE, SEQ_BURST} seq_state_t;

    seq_state_t       state_ff;
    seq_state_t       nxt_state;
    logic [FLD_W-1:0] index_ff;
    logic [FLD_W-1:0] nxt_index;
    logic [FLD_W-1:0] last_code;

    // Codes past the largest supported length are held to eighteen.
    assign last_code = (burst_length_i > FLD_W'(BURST_LEN_MAX))
                     ? FLD_W'(BURST_LEN_MAX)
                     : burst_length_i;

    always_comb
    begin
        nxt_state = state_ff;
        nxt_index = index_ff;
        case (state_ff)
            SEQ_IDLE:
            begin
                // R5: gated request
                if (update_evt_i && dma_en_i)
                begin
                    // R4: fresh burst
                    nxt_state = SEQ_BURST;
                    nxt_index = '0;
                end
            end
            SEQ_BURST:
            begin
                if (window_xfer_i)
                begin
                    // R11: length minus one
                    if (index_ff >= last_code)
                    begin
                        // R14: burst end
                        nxt_state = SEQ_IDLE;
                        nxt_index = '0;
                    end
                    else
                    begin
                        // R2: index advance
                        nxt_index = index_ff + 1'b1;
                    end
                end
            end
            default:
            begin
                nxt_state = SEQ_IDLE;
                nxt_index = '0;
            end
        endcase
    end

    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            state_ff <= SEQ_IDLE;
            index_ff <= '0;
        end
        else
        begin
            state_ff <= nxt_state;
            index_ff <= nxt_index;
        end
    end

    assign burst_index_o = index_ff;
    assign dma_req_o     = (state_ff == SEQ_BURST);

endmodule // burst_sequencer

// ===== design/timer_dma_burst_register_port.sv
// Operation
// R1: Window access reaches control_one plus base plus index.
// R2: Index advances per transfer, bounded by burst length.
// R3: Window data is 16 bits, reads zero after reset.
// R4: Each update request runs one full burst from base.
// R5: Request issued on update only when update DMA enable set.
// R6: DMA uses window as fixed peripheral address, RAM as memory.
// R7: DMA moves half-words, non-circular, count length times updates.
// R8: All registers 16-bit; upper bits read zero.
// R9: Channel mode read as output-compare or input-capture by direction.
// R10: Base 0xE, length 3, enable request, timer, then channel.
// R11: Length code is transfers minus one, max code eighteen transfers.
// R12: Base counts registers from control_one.
// R13: Redirected address is control_one plus four times base plus index.
// R14: After last transfer, index returns to zero, request withdrawn.
`timescale 1ns/1ps
module timer_dma_burst_register_port
    import burst_port_pkg::*;
(
    // Clock and reset.
    input  wire logic              clk_i,
    input  wire logic              sys_rst_i,
    // APB slave.
    input  wire logic              psel_i,
    input  wire logic              penable_i,
    input  wire logic              pwrite_i,
    input  wire logic [ADDR_W-1:0] paddr_i,
    input  wire logic [DATA_W-1:0] pwdata_i,
    output logic      [DATA_W-1:0] prdata_o,
    output logic                   pready_o,
    output logic                   pslverr_o,
    // DMA controller side.
    input  wire logic              dma_ack_i,
    output logic                   dma_req_o,
    // Timer core side.
    input  wire logic              update_evt_i,
    output logic                   output_compare_mode_o,
    output logic      [REG_W-1:0]  compare_value_o
);

    ////////////////////////////////////////////////////////////////////////////////

    logic [REG_W-1:0]       regs_ff [NUM_SLOTS];
    logic [BURST_FLD_W-1:0] burst_index;
    logic                   access;
    logic                   is_window;
    logic [ADDR_W-1:0]      eff_addr;
    logic [4:0]             eff_slot;
    logic                   eff_valid;
    logic [REG_W-1:0]       wmask;
    logic [REG_W-1:0]       rd_val;
    logic                   ug_write;
    logic                   update_evt_sync;
    logic                   update_all;
    logic [BURST_FLD_W:0]   slot_sum;
    logic [REG_W-1:0]       burst_ctrl;
    logic [REG_W-1:0]       chan_mode;

    assign access    = psel_i && penable_i;
    assign is_window = (paddr_i == OFS_BURST_WINDOW);
    // R10: base and length
    assign burst_ctrl = regs_ff[OFS_BURST_CONTROL[6:2]];
    assign chan_mode  = regs_ff[OFS_CHANNEL_MODE[6:2]];

    // R12: register count base
    // R13: four bytes per slot
    assign slot_sum = {1'b0, burst_ctrl[BASE_OFS_LSB +: BURST_FLD_W]}
                    + {1'b0, burst_index};

    // R1: window redirect
    assign eff_addr = is_window
                    ? (OFS_CONTROL_ONE + {slot_sum[ADDR_W-3:0], 2'b00})
                    : paddr_i;
    assign eff_slot  = eff_addr[6:2];

    // Holes and the window itself are not real storage.
    always_comb
    begin
        case (eff_addr)
            OFS_CONTROL_ONE, OFS_CONTROL_TWO, OFS_IRQ_DMA_ENABLE, OFS_STATUS_FLAGS,
            OFS_EVENT_GENERATE, OFS_CHANNEL_MODE, OFS_CHANNEL_EN_POL,
            OFS_COUNTER_VALUE, OFS_CLOCK_DIVIDER, OFS_RELOAD_VALUE, OFS_REPETITION,
            OFS_COMPARE_VALUE, OFS_BREAK_DEADTIME, OFS_BURST_CONTROL:
                eff_valid = (eff_addr[1:0] == 2'b00);
            default:
                eff_valid = 1'b0;
        endcase
    end

    always_comb
    begin
        case (eff_addr)
            OFS_CONTROL_ONE:    wmask = MASK_CONTROL_ONE;
            OFS_CONTROL_TWO:    wmask = MASK_CONTROL_TWO;
            OFS_IRQ_DMA_ENABLE: wmask = MASK_IRQ_DMA_ENABLE;
            OFS_STATUS_FLAGS:   wmask = MASK_STATUS_FLAGS;
            OFS_EVENT_GENERATE: wmask = '0;
            OFS_CHANNEL_MODE:   wmask = MASK_CHANNEL_MODE;
            OFS_CHANNEL_EN_POL: wmask = MASK_CHANNEL_EN_POL;
            OFS_REPETITION:     wmask = MASK_REPETITION;
            OFS_BURST_CONTROL:  wmask = MASK_BURST_CONTROL;
            default:            wmask = MASK_FULL;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////////

    // The update input comes from the same clock but is registered once so the
    // burst start and the status flag see one aligned event.
    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
            update_evt_sync <= 1'b0;
        else
            update_evt_sync <= update_evt_i;
    end

    assign ug_write   = access && pwrite_i && eff_valid
                     && (eff_addr == OFS_EVENT_GENERATE) && pwdata_i[UPD_GEN_BIT];
    assign update_all = update_evt_sync || ug_write;

    burst_sequencer #(
        .FLD_W (BURST_FLD_W)
    ) u_seq (
        .clk_i          (clk_i),
        .sys_rst_i      (sys_rst_i),
        .update_evt_i   (update_all),
        .dma_en_i       (regs_ff[OFS_IRQ_DMA_ENABLE[6:2]][UPD_DMA_EN_BIT]),
        .burst_length_i (burst_ctrl[LEN_CODE_LSB +: BURST_FLD_W]),
        .window_xfer_i  (access && is_window && dma_ack_i),
        .burst_index_o  (burst_index),
        .dma_req_o      (dma_req_o)
    );

    ////////////////////////////////////////////////////////////////////////////////

    // R8: sixteen bit storage
    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            for (int i = 0; i < NUM_SLOTS; i++)
                regs_ff[i] <= REG_RESET;
        end
        else
        begin
            if (access && pwrite_i && eff_valid)
            begin
                if (eff_addr == OFS_STATUS_FLAGS)
                    regs_ff[eff_slot] <= regs_ff[eff_slot] & (pwdata_i[REG_W-1:0] | ~wmask);
                else
                    regs_ff[eff_slot] <= (regs_ff[eff_slot] & ~wmask)
                                       | (pwdata_i[REG_W-1:0] & wmask);
            end
            // Hardware set wins over a software clear in the same cycle.
            if (update_all)
                regs_ff[OFS_STATUS_FLAGS[6:2]][UPD_FLAG_BIT] <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////

    always_comb
    begin
        rd_val = '0;
        if (eff_valid && (eff_addr != OFS_EVENT_GENERATE))
        begin
            rd_val = regs_ff[eff_slot];
            // R9: direction picks layout
            // Bit 7 has no meaning in the output-compare layout and reads zero.
            if ((eff_addr == OFS_CHANNEL_MODE)
                && (chan_mode[CHAN_DIR_LSB +: 2] == CHAN_DIR_OUT))
                rd_val = chan_mode & MASK_CHAN_MODE_OUT;
        end
    end

    // R3: window field
    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
            prdata_o <= '0;
        else if (psel_i && !penable_i && !pwrite_i)
            prdata_o <= {{(DATA_W-REG_W){1'b0}}, rd_val};
    end

    assign pready_o  = 1'b1;
    assign pslverr_o = access && !eff_valid;

    assign output_compare_mode_o = (chan_mode[CHAN_DIR_LSB +: 2] == CHAN_DIR_OUT);
    assign compare_value_o       = regs_ff[OFS_COMPARE_VALUE[6:2]];

endmodule // timer_dma_burst_register_port

// ===== bench/burst_port_assertions.sv
`timescale 1ns/1ps
module burst_port_checker
    import burst_port_pkg::*;
(
    // Clock, reset and APB.
    input wire logic              clk_i,
    input wire logic              sys_rst_i,
    input wire logic              psel_i,
    input wire logic              penable_i,
    input wire logic              pwrite_i,
    input wire logic [ADDR_W-1:0] paddr_i,
    input wire logic [DATA_W-1:0] pwdata_i,
    input wire logic [DATA_W-1:0] prdata_o,
    input wire logic              pready_o,
    input wire logic              pslverr_o,
    // DMA and timer core.
    input wire logic              dma_ack_i,
    input wire logic              dma_req_o,
    input wire logic              update_evt_i,
    input wire logic              output_compare_mode_o,
    input wire logic [REG_W-1:0]  compare_value_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);
    wire acc = psel_i && penable_i;
    wire win = acc && dma_ack_i && paddr_i == OFS_BURST_WINDOW;
    a_upper_zero: assert property (acc |-> prdata_o[31:16] == 16'h0000)
        else $error("upper read bits set");
    a_hole_err: assert property (acc && paddr_i inside {8'h08, 8'h1C, 8'h38} |-> pslverr_o)
        else $error("hole access not refused");
    a_err_idle: assert property (!acc |-> !pslverr_o)
        else $error("error outside access");
    a_rd_hold: assert property (!(psel_i && !penable_i && !pwrite_i) |=> $stable(prdata_o))
        else $error("read data moved");
    a_req_rise: assert property ($rose(dma_req_o) |->
        $past(update_evt_i, 2) || $past(acc && pwrite_i) || $past(acc && pwrite_i, 2))
        else $error("request without update");
    a_req_hold: assert property (dma_req_o && !win |=> dma_req_o)
        else $error("request dropped early");
    a_req_drop: assert property ($fell(dma_req_o) |-> $past(win) || $past(win, 2))
        else $error("request dropped without transfer");
    a_cmp_write: assert property ($changed(compare_value_o) |-> $past(acc && pwrite_i))
        else $error("compare changed without write");
endmodule // burst_port_checker
////////////////////////////////////////////////////////////////////////////////
bind timer_dma_burst_register_port burst_port_checker i_chk (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
    .pready_o(pready_o), .pslverr_o(pslverr_o), .dma_ack_i(dma_ack_i),
    .dma_req_o(dma_req_o), .update_evt_i(update_evt_i),
    .output_compare_mode_o(output_compare_mode_o), .compare_value_o(compare_value_o));

// ===== bench/dma_model.sv
`timescale 1ns/1ps
module dma_model
    import burst_port_pkg::*;
(
    // Clock and handshake.
    input  wire logic              clk_i,
    input  wire logic              dma_req_i,
    input  wire logic              pready_i,
    // APB master side.
    output logic                   psel_o,
    output logic                   penable_o,
    output logic                   pwrite_o,
    output logic      [ADDR_W-1:0] paddr_o,
    output logic      [DATA_W-1:0] pwdata_o,
    output logic                   dma_ack_o
);
    // Set by the bench between bursts only.
    logic        wr_ff    = 1'b0;
    int          stall_ff = 0;
    int          done_ff  = 0;
    logic [15:0] mem_q[$];
    initial {psel_o, penable_o, pwrite_o, paddr_o, pwdata_o, dma_ack_o} = '0;

    // Released address and data lines show the inverse, so stale values never look valid.
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        input logic k);
        {psel_o, pwrite_o, paddr_o, pwdata_o, dma_ack_o} <= {1'b1, w, a, d, k};
        @(posedge clk_i);
        penable_o <= 1'b1;
        @(posedge clk_i);
        while (pready_i !== 1'b1)
            @(posedge clk_i);
        {psel_o, penable_o, paddr_o, pwdata_o, dma_ack_o} <= {2'b00, ~a, ~d, 1'b0};
        // One idle edge keeps the next request out of the release step.
        @(posedge clk_i);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    // fixed window, half-words
    always @(posedge clk_i)
        if (dma_req_i === 1'b1)
        begin
            repeat (stall_ff) @(posedge clk_i);
            xfer(wr_ff, OFS_BURST_WINDOW, {16'h0000, wr_ff ? mem_q.pop_front() : 16'h0000}, 1'b1);
            done_ff++;
            @(posedge clk_i);
        end
endmodule // dma_model

// ===== bench/tb.sv
`timescale 1ns/1ps
module tb;
    import burst_port_pkg::*;
    typedef struct packed { logic [31:0] d; logic e; logic w; } note_t;
    logic              clk_i = 1'b0;
    logic              sys_rst_i = 1'b1;
    logic              update_evt_i = 1'b0;
    logic              psel_i, penable_i, pwrite_i, dma_ack_i;
    logic [ADDR_W-1:0] paddr_i;
    logic [DATA_W-1:0] pwdata_i, prdata_o;
    logic              pready_o, pslverr_o, dma_req_o, output_compare_mode_o;
    logic [REG_W-1:0]  compare_value_o;
    int                miscompares = 0;
    int                compares = 0;
    int                seed = 32'h89565d62;
    logic [15:0]       word_q[$];
    note_t             note_q[$];
    note_t             cur;
    logic [4:0]        lens [4] = '{5'h00, 5'h02, BURST_LEN_MAX, 5'h1F};
    int                cnts [4] = '{1, 3, 18, 18};
    always #2 clk_i = ~clk_i;

    timer_dma_burst_register_port i_dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
        .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
        .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
        .pslverr_o(pslverr_o), .dma_ack_i(dma_ack_i), .dma_req_o(dma_req_o),
        .update_evt_i(update_evt_i), .output_compare_mode_o(output_compare_mode_o),
        .compare_value_o(compare_value_o));
    dma_model i_dma (.clk_i(clk_i), .dma_req_i(dma_req_o), .pready_i(pready_o),
        .psel_o(psel_i), .penable_o(penable_i), .pwrite_o(pwrite_i), .paddr_o(paddr_i),
        .pwdata_o(pwdata_i), .dma_ack_o(dma_ack_i));
    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp)
        begin
            miscompares++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic end_sim();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d,
                       input logic [31:0] x, input logic e);
        note_q.push_back('{x, e, w});
        i_dma.xfer(w, a, d, 1'b0);
    endtask
    task automatic burst(input logic [4:0] l, input logic [4:0] b, input logic w, input int n);
        acc(1'b1, OFS_BURST_CONTROL, {19'h0, l, 3'h0, b}, 32'h0, 1'b0);
        i_dma.wr_ff = w;
        i_dma.done_ff = 0;
        i_dma.stall_ff = {$random(seed)} % 3;
        update_evt_i <= 1'b1;
        @(posedge clk_i);
        update_evt_i <= 1'b0;
        repeat (3) @(posedge clk_i);
        for (int t = 0; t < 400 && dma_req_o !== 1'b0; t++)
            @(posedge clk_i);
        chk({31'h0, dma_req_o}, 32'h0);
        repeat (2) @(posedge clk_i);
        chk(i_dma.done_ff, n);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    always @(posedge clk_i)
        if (psel_i && penable_i && pready_o && !dma_ack_i && note_q.size() > 0)
        begin
            cur = note_q.pop_front();
            chk({31'h0, pslverr_o}, {31'h0, cur.e});
            if (!cur.w)
                chk(prdata_o, cur.d);
        end
    initial
    begin
        repeat (20) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        @(posedge clk_i);
        for (int s = 0; s < 20; s++)
            acc(1'b0, 8'(s * 4), 0, 0, s inside {2, 7, 14, 15, 16});
        acc(1'b1, OFS_COUNTER_VALUE, 32'hFFFFFFFF, 0, 0);
        acc(1'b0, OFS_COUNTER_VALUE, 0, 32'h0000FFFF, 0);
        acc(1'b1, OFS_BURST_CONTROL, 32'h0000FFFF, 0, 0);
        acc(1'b0, OFS_BURST_CONTROL, 0, 32'h00001F1F, 0);
        acc(1'b1, OFS_CHANNEL_MODE, 32'h81, 0, 0);
        acc(1'b0, OFS_CHANNEL_MODE, 0, 32'h00000081, 0);
        chk({31'h0, output_compare_mode_o}, 32'h0);
        acc(1'b1, OFS_CHANNEL_MODE, 32'h80, 0, 0);
        acc(1'b0, OFS_CHANNEL_MODE, 0, 32'h00000000, 0);
        chk({31'h0, output_compare_mode_o}, 32'h1);
        burst(5'h02, 5'h09, 1'b1, 0);
        acc(1'b1, OFS_IRQ_DMA_ENABLE, 32'h1 << UPD_DMA_EN_BIT, 0, 0);
        foreach (lens[i])
            burst(lens[i], 5'h00, 1'b0, cnts[i]);
        repeat (6) i_dma.mem_q.push_back(16'($random(seed)));
        word_q = i_dma.mem_q;
        burst(5'h02, 5'h09, 1'b1, 3);
        acc(1'b0, OFS_BURST_WINDOW, 0, {16'h0, word_q[0]}, 0);
        burst(5'h02, 5'h09, 1'b1, 3);
        for (int i = 0; i < 3; i++)
            acc(1'b0, 8'(OFS_COUNTER_VALUE + 4 * i), 0, {16'h0, word_q[3 + i]}, 0);
        i_dma.mem_q.push_back(16'hA5C3);
        burst(5'h00, 5'h0D, 1'b1, 1);
        chk({16'h0, compare_value_o}, 32'h0000A5C3);
        acc(1'b1, OFS_BURST_CONTROL, 32'h0000020E, 0, 0);
        acc(1'b0, OFS_BURST_WINDOW, 0, 0, 1);
        end_sim();
    end
    // About 500 cycles are needed; the limit of 10000 cycles leaves twentyfold margin.
    initial
    begin
        #40000;
        miscompares++;
        end_sim();
    end
endmodule // tb
